/* hdl/timer_pair_defs.svh */
// constants for the paired general-purpose timer: widths, event bit positions,
// and the real-time-clock divider. included by bare name; definitions only.
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH

// width of one half counter; 32 gives the wide (64-bit joined) variant
`define HALF_WIDTH      16

// real-time-clock reference: 32 KHz pin divided to one tick per second
`define RTC_CLK_HZ      32768
`define RTC_TICK_S      1

// positions in the event and event-enable vectors
`define EVT_WIDTH       7
`define EVT_TMO_A       0
`define EVT_CAP_A       1
`define EVT_CAPMATCH_A  2
`define EVT_TMO_B       3
`define EVT_CAP_B       4
`define EVT_CAPMATCH_B  5
`define EVT_RTC_MATCH   6

`endif

/* hdl/timer_pair_pkg.sv */
// types shared by the paired timer and its half counters.
// no dependencies.
package timer_pair_pkg;

  // joined (full-width) configuration
  typedef enum logic [1:0] {
    PM_ONE_SHOT = 2'b00,
    PM_PERIODIC = 2'b01,
    PM_RTC      = 2'b10,
    PM_SPLIT    = 2'b11
  } pair_mode_t;

  // per-half configuration used in split operation
  typedef enum logic [2:0] {
    HM_ONE_SHOT        = 3'b000,
    HM_PERIODIC        = 3'b001,
    HALF_EDGE_COUNTING = 3'b010,
    HALF_EDGE_TIMING   = 3'b011,
    HM_PWM             = 3'b100
  } half_mode_t;

  // qualifying capture edge
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } edge_sel_t;

endpackage

/* hdl/half_counter.sv */
// one half-width counter: one-shot, periodic, edge count, edge time, pwm.
// assumes capLevel is already synchronised to mclk and run is gated by the parent.
`timescale 1ns/10ps
module half_counter
  import timer_pair_pkg::*;
#(
  parameter int W = 16
)
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire half_mode_t   mode,
  input  wire logic         countUp,
  input  wire edge_sel_t    edgeSel,
  input  wire logic [W-1:0] loadVal,
  input  wire logic         loadWr,
  input  wire logic [W-1:0] matchVal,
  input  wire logic         capLevel,
  // results
  output logic [W-1:0]      value,
  output logic [W-1:0]      captured,
  output logic              timeout,
  output logic              capEvent,
  output logic              capMatch,
  output logic              pwmLevel
);

  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] cap_ff;
  logic         done_ff;
  logic         prevLvl_ff;
  logic         tmo_ff;
  logic         evt_ff;
  logic         mat_ff;
  logic         pwm_ff;

  // edge qualification and mode decode
  wire          rise      = capLevel & ~prevLvl_ff;
  wire          fall      = ~capLevel & prevLvl_ff;
  wire          edgeHit   = (edgeSel == EDGE_RISE && rise) ||
                            (edgeSel == EDGE_FALL && fall) ||
                            (edgeSel == EDGE_BOTH && (rise || fall)); // R7
  wire          isCount   = (mode == HALF_EDGE_COUNTING);
  wire          isCapture = isCount || (mode == HALF_EDGE_TIMING);
  wire          oneShot   = (mode == HM_ONE_SHOT);
  wire          useUp     = countUp && (mode != HM_PWM); // pwm always counts down
  wire          edgeEvt   = run && isCapture && edgeHit; // R20
  wire [W-1:0]  startVal  = useUp ? '0 : loadVal;
  wire [W-1:0]  endVal    = useUp ? loadVal : '0;
  wire          atEnd     = (cnt_ff == endVal);
  wire [W-1:0]  stepped   = useUp ? cnt_ff + ONE : cnt_ff - ONE;
  // edge counting steps on qualified edges only; timers step every cycle
  wire          advance   = run && (isCount ? edgeHit : 1'h1) && !(oneShot && done_ff); // R6
  wire          wrapNow   = advance && atEnd;

  // counter, one-shot stop and periodic reload
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= '0;
      done_ff <= 1'h0;
    end
    else if (loadWr)
    begin
      cnt_ff  <= startVal;
      done_ff <= 1'h0;
    end
    else if (wrapNow && oneShot)
      done_ff <= 1'h1; // R3
    else if (wrapNow)
      cnt_ff  <= startVal; // R4
    else if (advance)
      cnt_ff  <= stepped;
  end

  // event pulses, capture register and pwm level
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prevLvl_ff <= 1'h0;
      tmo_ff     <= 1'h0;
      evt_ff     <= 1'h0;
      mat_ff     <= 1'h0;
      cap_ff     <= '0;
      pwm_ff     <= 1'h0;
    end
    else
    begin
      prevLvl_ff <= capLevel; // tracked while idle so enabling sees no false edge
      tmo_ff     <= wrapNow && !loadWr; // R10
      evt_ff     <= edgeEvt; // R9
      mat_ff     <= edgeEvt && isCount && (stepped == matchVal); // R9
      if (edgeEvt && !isCount)
        cap_ff   <= cnt_ff; // R6
      if (run && mode == HM_PWM)
        pwm_ff   <= (cnt_ff > matchVal); // R8
    end
  end

  assign value    = cnt_ff;
  assign captured = cap_ff;
  assign timeout  = tmo_ff;
  assign capEvent = evt_ff;
  assign capMatch = mat_ff;
  assign pwmLevel = pwm_ff;

endmodule // half_counter

/* hdl/timer_pair.sv */
// paired general-purpose timer: two half counters or one joined counter / rtc.
// assumes config ports come from on-chip logic on mclk; pins and the 32 KHz
// reference are asynchronous and are synchronised here.
//
// Summary of operation
// R1: two half counters run alone or join into one full timer or rtc.
// R2: half width is a parameter; 32 gives two 32-bit halves joining to 64.
// R3: one-shot counting stops at the end value and does not reload.
// R4: periodic counting restarts from the load value (down) or zero (up) at the end and continues.
// R5: rtc mode advances once per second from the divided 32 KHz pin.
// R6: capture modes either time input edges or count them.
// R7: capture edge is rising, falling or both.
// R8: pwm mode turns the capture pin into an edge-aligned pulse output.
// R9: events flag each captured edge and reaching the programmed edge count.
// R10: events flag timeout and rtc value equal to match value.
// R11: mode settings are taken only while the timer is disabled.
// R12: joined modes are one-shot, periodic, rtc, or split, with up-count option.
// R13: each half offers one-shot, periodic, edge count, edge time and pwm.
// R14: each half keeps its own independently latched mode settings.
// R15: output inversion, trigger output enable and stall behaviour are selectable.
// R16: with stall enabled the counter freezes during debug halt.
// R17: wait-on-trigger holds counting until the preceding timer times out.
// R18: inversion makes the pwm output active low, else active high.
// R19: only enabled events reach the interrupt line.
// R20: a disabled counter holds its value and raises no events.
`timescale 1ns/10ps
`include "timer_pair_defs.svh"
module timer_pair
  import timer_pair_pkg::*;
#(
  parameter int W       = `HALF_WIDTH, // R2
  parameter int RTC_DIV = `RTC_CLK_HZ * `RTC_TICK_S
)
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // configuration, taken while disabled
  input  wire pair_mode_t            pairMode,
  input  wire half_mode_t            modeA,
  input  wire half_mode_t            modeB,
  input  wire edge_sel_t             edgeSelA,
  input  wire edge_sel_t             edgeSelB,
  input  wire logic [1:0]            countUp,
  input  wire logic [1:0]            invertOut,
  input  wire logic [1:0]            trigOutEn,
  input  wire logic [1:0]            stallEn,
  input  wire logic [1:0]            waitTrigEn,
  // run control and values
  input  wire logic [1:0]            enable,
  input  wire logic [W-1:0]          loadA,
  input  wire logic [W-1:0]          loadB,
  input  wire logic [1:0]            loadWr,
  input  wire logic [W-1:0]          matchA,
  input  wire logic [W-1:0]          matchB,
  // system
  input  wire logic                  debugHalt,
  input  wire logic                  trigIn,
  output logic [1:0]                 trigOut,
  // pins
  input  wire logic [1:0]            capPinIn,
  output logic [1:0]                 capPinOut,
  output logic [1:0]                 capPinOe,
  input  wire logic                  rtcClkPin,
  // status and events
  output logic [W-1:0]               valueA,
  output logic [W-1:0]               valueB,
  output logic [W-1:0]               capturedA,
  output logic [W-1:0]               capturedB,
  output logic [`EVT_WIDTH-1:0]      eventRaw,
  input  wire logic [`EVT_WIDTH-1:0] eventEn,
  output logic                       irq
);

  localparam int FW = 2 * W;
  localparam logic [FW-1:0] FONE = FW'(1);
  localparam int DW = $clog2(RTC_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(RTC_DIV - 1);

  // latched configuration
  pair_mode_t   pairCfg_ff;
  half_mode_t   modeCfg_ff [2];
  edge_sel_t    edgeCfg_ff [2];
  logic [1:0]   upCfg_ff;
  logic [1:0]   invCfg_ff;
  logic [1:0]   trigCfg_ff;
  logic [1:0]   stallCfg_ff;
  logic [1:0]   waitCfg_ff;

  // synchronisers: bits 1:0 capture pins, bit 2 rtc reference
  logic [2:0]   pinMeta_ff;
  logic [2:0]   pinSync_ff;

  // trigger chain and pin drive
  logic [1:0]   started_ff;
  logic [1:0]   pinOut_ff;

  // joined counter
  logic [FW-1:0] fullCnt_ff;
  logic          fullDone_ff;
  logic          fullTmo_ff;
  logic          rtcMatch_ff;
  logic          rtcPrev_ff;
  logic [DW-1:0] rtcDiv_ff;

  // half results
  logic [W-1:0] halfVal [2];
  logic [W-1:0] halfCap [2];
  logic [1:0]   halfTmo;
  logic [1:0]   halfEvt;
  logic [1:0]   halfMat;
  logic [1:0]   halfPwm;

  // per-half views of the flat ports
  wire half_mode_t  modeIn [2] = '{modeA, modeB};
  wire edge_sel_t   edgeIn [2] = '{edgeSelA, edgeSelB};
  wire logic [W-1:0] loadIn [2] = '{loadA, loadB};
  wire logic [W-1:0] matchIn [2] = '{matchA, matchB};

  // configuration is taken only while the owning timer is disabled
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pairCfg_ff <= PM_SPLIT;
    else if (enable == 2'h0)
      pairCfg_ff <= pairMode; // R11
  end

  wire split = (pairCfg_ff == PM_SPLIT); // R1

  // two-flop synchronisers for all asynchronous pins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end
    else
    begin
      pinMeta_ff <= {rtcClkPin, capPinIn};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // the halves; timer B waits on timer A, timer A on the external trigger
  wire [1:0] chainTrig = {halfTmo[0] | fullTmo_ff, trigIn};
  wire [1:0] go        = ~waitCfg_ff | started_ff; // R17
  wire [1:0] frozen    = stallCfg_ff & {2{debugHalt}}; // R16
  wire [1:0] runAny    = enable & go & ~frozen; // R20

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_half
      // per-half settings, each latched independently
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          modeCfg_ff[i]  <= HM_ONE_SHOT;
          edgeCfg_ff[i]  <= EDGE_RISE;
          upCfg_ff[i]    <= 1'h0;
          invCfg_ff[i]   <= 1'h0;
          trigCfg_ff[i]  <= 1'h0;
          stallCfg_ff[i] <= 1'h0;
          waitCfg_ff[i]  <= 1'h0;
        end
        else if (!enable[i])
        begin
          modeCfg_ff[i]  <= modeIn[i]; // R14
          edgeCfg_ff[i]  <= edgeIn[i];
          upCfg_ff[i]    <= countUp[i];
          invCfg_ff[i]   <= invertOut[i]; // R15
          trigCfg_ff[i]  <= trigOutEn[i];
          stallCfg_ff[i] <= stallEn[i];
          waitCfg_ff[i]  <= waitTrigEn[i];
        end
      end

      // trigger arm: cleared on disable, set by the preceding timeout
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          started_ff[i] <= 1'h0;
        else if (!enable[i])
          started_ff[i] <= 1'h0;
        else if (chainTrig[i])
          started_ff[i] <= 1'h1; // R17
      end

      half_counter #(
        .W        (W)
      ) u_half (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .run      (runAny[i] && split), // R13
        .mode     (modeCfg_ff[i]),
        .countUp  (upCfg_ff[i]),
        .edgeSel  (edgeCfg_ff[i]),
        .loadVal  (loadIn[i]),
        .loadWr   (loadWr[i] && split),
        .matchVal (matchIn[i]),
        .capLevel (pinSync_ff[i]),
        .value    (halfVal[i]),
        .captured (halfCap[i]),
        .timeout  (halfTmo[i]),
        .capEvent (halfEvt[i]),
        .capMatch (halfMat[i]),
        .pwmLevel (halfPwm[i])
      );

      // pin drive registered; polarity applied here
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          pinOut_ff[i] <= 1'h0;
        else
          pinOut_ff[i] <= halfPwm[i] ^ invCfg_ff[i]; // R18
      end

      assign capPinOe[i]  = split && (modeCfg_ff[i] == HM_PWM); // R8
      assign capPinOut[i] = pinOut_ff[i];
    end
  endgenerate

  // joined counter decode; half A's enable and settings steer it
  wire          fullRun   = runAny[0] && !split; // R12
  wire          isRtc     = (pairCfg_ff == PM_RTC);
  wire          fullShot  = (pairCfg_ff == PM_ONE_SHOT);
  wire          fullUp    = upCfg_ff[0] || isRtc;
  wire [FW-1:0] fullLoad  = {loadB, loadA};
  wire [FW-1:0] fullMatch = {matchB, matchA};
  wire [FW-1:0] fullStart = fullUp ? '0 : fullLoad;
  wire [FW-1:0] fullEnd   = fullUp ? fullLoad : '0;
  wire [FW-1:0] fullStep  = fullUp ? fullCnt_ff + FONE : fullCnt_ff - FONE;
  wire          fullLdWr  = loadWr[0] && !split;
  wire          rtcEdge   = pinSync_ff[2] && !rtcPrev_ff;
  wire          secTick   = fullRun && isRtc && rtcEdge && (rtcDiv_ff == DIV_LAST); // R5
  wire          fullAdv   = fullRun && !isRtc && !(fullShot && fullDone_ff);
  wire          fullWrap  = fullAdv && (fullCnt_ff == fullEnd);

  // rtc prescaler: counts reference edges, wraps once per second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rtcPrev_ff <= 1'h0;
      rtcDiv_ff  <= '0;
    end
    else
    begin
      rtcPrev_ff <= pinSync_ff[2];
      if (!(fullRun && isRtc))
        rtcDiv_ff <= '0;
      else if (rtcEdge)
        rtcDiv_ff <= (rtcDiv_ff == DIV_LAST) ? '0 : rtcDiv_ff + DW'(1); // R5
    end
  end

  // joined counter: one-shot, periodic or rtc seconds
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fullCnt_ff  <= '0;
      fullDone_ff <= 1'h0;
    end
    else if (fullLdWr)
    begin
      fullCnt_ff  <= isRtc ? fullLoad : fullStart;
      fullDone_ff <= 1'h0;
    end
    else if (secTick)
      fullCnt_ff  <= fullCnt_ff + FONE; // R5
    else if (fullWrap && fullShot)
      fullDone_ff <= 1'h1; // R3
    else if (fullWrap)
      fullCnt_ff  <= fullStart; // R4
    else if (fullAdv)
      fullCnt_ff  <= fullStep;
  end

  // joined events, one cycle each
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fullTmo_ff  <= 1'h0;
      rtcMatch_ff <= 1'h0;
    end
    else
    begin
      fullTmo_ff  <= fullWrap && !fullLdWr; // R10
      rtcMatch_ff <= secTick && !fullLdWr && (fullCnt_ff + FONE == fullMatch); // R10
    end
  end

  // status views: values show halves in split, joined value otherwise; captures always show the halves
  assign valueA    = split ? halfVal[0] : fullCnt_ff[W-1:0];
  assign valueB    = split ? halfVal[1] : fullCnt_ff[FW-1:W];
  assign capturedA = halfCap[0];
  assign capturedB = halfCap[1];

  // event vector and gated interrupt line
  assign eventRaw[`EVT_TMO_A]      = halfTmo[0] | fullTmo_ff;
  assign eventRaw[`EVT_CAP_A]      = halfEvt[0];
  assign eventRaw[`EVT_CAPMATCH_A] = halfMat[0];
  assign eventRaw[`EVT_TMO_B]      = halfTmo[1];
  assign eventRaw[`EVT_CAP_B]      = halfEvt[1];
  assign eventRaw[`EVT_CAPMATCH_B] = halfMat[1];
  assign eventRaw[`EVT_RTC_MATCH]  = rtcMatch_ff;
  assign irq     = |(eventRaw & eventEn); // R19
  assign trigOut = trigCfg_ff & {halfTmo[1], halfTmo[0] | fullTmo_ff}; // R15

endmodule // timer_pair

/* tb/timer_pair_checker.sv */
// concurrent checks on the paired timer ports, bound into every timer_pair.
// assumes the bench keeps configuration steady while a half is running.
`timescale 1ns/10ps
module timer_pair_checker
  import timer_pair_pkg::*;
#(
  parameter int W = 16
)
(
  // clock and reset
  input wire logic         mclk,
  input wire logic         rst_n,
  // configuration and control
  input wire pair_mode_t   pairMode,
  input wire half_mode_t   modeA,
  input wire logic [1:0]   countUp,
  input wire logic [1:0]   stallEn,
  input wire logic [1:0]   enable,
  input wire logic [1:0]   loadWr,
  input wire logic         debugHalt,
  input wire logic [6:0]   eventEn,
  // results
  input wire logic [1:0]   trigOut,
  input wire logic [1:0]   capPinOe,
  input wire logic [W-1:0] valueA,
  input wire logic [6:0]   eventRaw,
  input wire logic         irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // interrupt line is the masked event vector, nothing more
  a_irq_masked: assert property (irq == |(eventRaw & eventEn))
    else $error("irq differs from enabled events");
  // two idle cycles flush the event pipeline
  a_idle_quiet: assert property (
    $past(enable) == 2'b00 && $past(enable, 2) == 2'b00 |-> eventRaw == 7'h00)
    else $error("event while disabled");
  // a pair mode change while disabled swaps the status view, so it is left out
  a_hold_value: assert property (
    !$past(enable[0]) && !$past(loadWr[0]) && $past(pairMode) == $past(pairMode, 2)
    |-> $stable(valueA)) else $error("value moved while disabled");
  a_oe_follows: assert property ($past(enable) == 2'b00 |-> capPinOe[0] ==
    ($past(pairMode) == PM_SPLIT && $past(modeA) == HM_PWM))
    else $error("pin direction wrong for mode");
  a_cfg_locked: assert property ($past(enable[0]) |-> $stable(capPinOe[0]))
    else $error("config taken while enabled");
  a_trig_tmo: assert property ((trigOut & ~{eventRaw[3], eventRaw[0]}) == 2'b00)
    else $error("trigger without timeout");
  a_tmo_zero: assert property (eventRaw[0] && !countUp[0] |-> $past(valueA) == '0)
    else $error("timeout not from zero");
  a_stall_hold: assert property (
    $past(stallEn[0] && debugHalt && !loadWr[0]) |-> $stable(valueA))
    else $error("counter ran during stall");
endmodule // timer_pair_checker

bind timer_pair timer_pair_checker #(.W(W)) u_chk (.mclk, .rst_n, .pairMode, .modeA,
  .countUp, .stallEn, .enable, .loadWr, .debugHalt, .eventEn, .trigOut, .capPinOe,
  .valueA, .eventRaw, .irq);

/* tb/tb_timer_pair.sv */
// directed bench for the paired timer: modes, capture, pwm, rtc, masking.
// assumes the design package and header are compiled first; rtc divider is 4.
`timescale 1ns/10ps
module tb_timer_pair;
  import timer_pair_pkg::*;

  logic        mclk;
  logic        rst_n;
  pair_mode_t  pairMode;
  half_mode_t  modeA, modeB;
  edge_sel_t   edgeSelA, edgeSelB;
  logic [1:0]  countUp, invertOut, trigOutEn, stallEn, waitTrigEn, enable, loadWr;
  logic [1:0]  trigOut, capPinIn, capPinOut, capPinOe;
  logic [15:0] loadA, loadB, matchA, matchB, valueA, valueB, capturedA, capturedB, v, w;
  logic        debugHalt, trigIn, rtcClkPin, irq;
  logic [6:0]  eventRaw, eventEn;
  int          err_count, cmp_count, cyc, nIrq, nHi, nTrig;
  int          n [7];
  int          per [2];
  int          last [2];

  timer_pair #(.W(16), .RTC_DIV(4)) u_dut (.mclk, .rst_n, .pairMode, .modeA, .modeB,
    .edgeSelA, .edgeSelB, .countUp, .invertOut, .trigOutEn, .stallEn, .waitTrigEn,
    .enable, .loadA, .loadB, .loadWr, .matchA, .matchB, .debugHalt, .trigIn, .trigOut,
    .capPinIn, .capPinOut, .capPinOe, .rtcClkPin, .valueA, .valueB, .capturedA,
    .capturedB, .eventRaw, .eventEn, .irq);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // event tallies and period of each timeout; also the hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    nIrq <= nIrq + irq;
    nHi <= nHi + capPinOut[0];
    nTrig <= nTrig + trigOut[1];
    for (int i = 0; i < 7; i++)
      if (eventRaw[i] === 1'b1) n[i] <= n[i] + 1;
    for (int j = 0; j < 2; j++)
      if (eventRaw[3 * j] === 1'b1)
      begin
        per[j] <= cyc - last[j];
        last[j] <= cyc;
      end
    if (cyc > 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // waits c edges, then lets their updates settle
  task automatic tk(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  task automatic run(input logic [1:0] e);
    @(posedge mclk);
    enable <= e;
  endtask

  // disable, set modes, load both halves, then clear the event, irq and trigger tallies
  task automatic cfg(input pair_mode_t p, input half_mode_t a, input half_mode_t b,
                     input logic [15:0] la, input logic [15:0] lb);
    run(2'b00);
    pairMode <= p;
    modeA <= a;
    modeB <= b;
    loadA <= la;
    loadB <= lb;
    @(posedge mclk);
    loadWr <= 2'b11;
    @(posedge mclk);
    loadWr <= 2'b00;
    tk(3);
    n = '{default: 0};
    nIrq = 0;
    nTrig = 0;
  endtask

  // k pulses on both capture pins, ten cycles rise to rise
  task automatic pls(input int k);
    repeat (k)
    begin
      @(posedge mclk);
      capPinIn <= 2'b11;
      tk(4);
      @(posedge mclk);
      capPinIn <= 2'b00;
      tk(4);
    end
  endtask

  initial
  begin
    {rst_n, countUp, invertOut, stallEn, waitTrigEn, enable, loadWr} = '0;
    {loadA, loadB, matchA, matchB, debugHalt, trigIn, capPinIn, rtcClkPin} = '0;
    {err_count, cmp_count, cyc, nIrq, nHi, nTrig} = '0;
    pairMode = PM_SPLIT;
    modeA = HM_ONE_SHOT;
    modeB = HM_ONE_SHOT;
    edgeSelA = EDGE_RISE;
    edgeSelB = EDGE_RISE;
    trigOutEn = 2'b10;
    eventEn = 7'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    tk(2);
    chk({capPinOe, irq, eventRaw, valueA[5:0]}, 16'h0000);
    // one-shot first half beside a periodic second half, both masked
    cfg(PM_SPLIT, HM_ONE_SHOT, HM_PERIODIC, 16'h0005, 16'h0003);
    run(2'b11);
    tk(40);
    chk(n[0], 16'h0001);
    chk(valueA, 16'h0000);
    chk(per[1], 16'h0004);
    chk(nIrq, 16'h0000);
    chk(nTrig == n[3] && n[3] > 5, 1'b1);
    // periodic down then up: period is load plus one either way
    for (int c = 0; c < 2; c++)
    begin
      @(posedge mclk);
      countUp <= c[1:0];
      eventEn <= 7'h01;
      cfg(PM_SPLIT, HM_PERIODIC, HM_PERIODIC, 16'h0005, 16'h0003);
      run(2'b11);
      tk(30);
      chk(per[0], 16'h0006);
      chk(nIrq == n[0] && n[0] > 3, 1'b1);
    end
    // disabled counter holds still
    run(2'b00);
    tk(1);
    v = valueA;
    tk(8);
    chk(valueA, v);
    // stall freezes only while debug halt is held
    stallEn <= 2'b01;
    countUp <= 2'b00;
    cfg(PM_SPLIT, HM_PERIODIC, HM_ONE_SHOT, 16'h0064, 16'h0000);
    run(2'b01);
    tk(3);
    debugHalt <= 1'b1;
    tk(2);
    v = valueA;
    tk(8);
    chk(valueA, v);
    debugHalt <= 1'b0;
    tk(3);
    chk(valueA == v, 1'b0);
    // wait-on-trigger: idle until the external trigger arrives
    stallEn <= 2'b00;
    waitTrigEn <= 2'b01;
    cfg(PM_SPLIT, HM_PERIODIC, HM_ONE_SHOT, 16'h0032, 16'h0000);
    run(2'b01);
    tk(8);
    chk(valueA, 16'h0032);
    trigIn <= 1'b1;
    @(posedge mclk);
    trigIn <= 1'b0;
    tk(4);
    chk(valueA < 16'h0032, 1'b1);
    waitTrigEn <= 2'b00;
    // mode change while running is refused
    run(2'b01);
    modeA <= HM_PWM;
    tk(3);
    chk(capPinOe[0], 1'b0);
    // pwm duty over two whole periods: high while count above match
    matchA <= 16'h0002;
    for (int i = 0; i < 2; i++)
    begin
      invertOut <= i[1:0];
      cfg(PM_SPLIT, HM_PWM, HM_ONE_SHOT, 16'h0007, 16'h0000);
      chk(capPinOe[0], 1'b1);
      run(2'b01);
      tk(20);
      nHi = 0;
      tk(16);
      chk(nHi, (i == 0) ? 16'h000A : 16'h0006);
    end
    // edge counting for each edge choice, match at seven
    matchA <= 16'h0007;
    for (int e = 0; e < 3; e++)
    begin
      edgeSelA <= edge_sel_t'(e);
      cfg(PM_SPLIT, HALF_EDGE_COUNTING, HM_ONE_SHOT, 16'h000A, 16'h0000);
      run(2'b01);
      pls(3);
      tk(6);
      chk(n[1], (e == 2) ? 16'h0006 : 16'h0003);
      chk(valueA, (e == 2) ? 16'h0004 : 16'h0007);
      chk(n[2], 16'h0001);
    end
    // edge timing: two rises ten cycles apart
    edgeSelA <= EDGE_RISE;
    cfg(PM_SPLIT, HALF_EDGE_TIMING, HALF_EDGE_TIMING, 16'hFFFF, 16'hFFFF);
    run(2'b11);
    pls(1);
    v = capturedA;
    w = capturedB;
    pls(1);
    chk(v - capturedA, 16'h000A);
    chk(w - capturedB, 16'h000A);
    chk(n[4], 16'h0002);
    // joined counter borrows from the upper half
    cfg(PM_ONE_SHOT, HM_ONE_SHOT, HM_ONE_SHOT, 16'h0000, 16'h0001);
    run(2'b01);
    tk(3);
    chk(valueB, 16'h0000);
    chk(valueA > 16'hFFF0, 1'b1);
    // joined periodic: full-width reload, timeout every load plus one
    cfg(PM_PERIODIC, HM_ONE_SHOT, HM_ONE_SHOT, 16'h0003, 16'h0000);
    run(2'b01);
    tk(20);
    chk(per[0], 16'h0004);
    // rtc: four reference rises per tick, match at two
    matchA <= 16'h0002;
    eventEn <= 7'h40;
    cfg(PM_RTC, HM_ONE_SHOT, HM_ONE_SHOT, 16'h0000, 16'h0000);
    run(2'b01);
    repeat (8)
    begin
      rtcClkPin <= 1'b1;
      tk(3);
      @(posedge mclk);
      rtcClkPin <= 1'b0;
      tk(3);
      @(posedge mclk);
    end
    tk(6);
    chk(valueA, 16'h0002);
    chk(n[6], 16'h0001);
    chk(nIrq, 16'h0001);
    end_sim();
  end
endmodule // tb_timer_pair
